/* File: shared/cdsg_pkg.sv */
// Package of constants for the clock divider and standby gating block
package cdsg_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_PRESCALE = 8'h00;
  localparam logic [7:0] OFS_MONITOR = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_INTERMIT = 8'h10;

  // ****************************************************************
  // Field positions and widths
  // ****************************************************************
  localparam int PRESC_W = 3;
  localparam int MONSEL_W = 3;
  localparam int SRC_LSB = 0;
  localparam int MODE_LSB = 4;
  localparam int HWSTBY_BIT = 0;
  localparam int INT_ON_LSB = 0;
  localparam int INT_OFF_LSB = 16;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [2:0] PRESC_RST = 3'h2;
  localparam logic [2:0] MONSEL_RST = 3'h0;
  localparam logic [1:0] SRC_RST = 2'h1;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [15:0] INT_ON_RST = 16'h0010;
  localparam logic [15:0] INT_OFF_RST = 16'h0030;

  // ****************************************************************
  // Ratio limits
  // ****************************************************************
  localparam logic [2:0] PRESC_MIN = 3'h2;
  localparam logic [3:0] PRESC_MAX = 4'h8;
  localparam logic [2:0] PRESC_FIELD_MAX = 3'h7;

  // ****************************************************************
  // Clock sources and operating modes
  // ****************************************************************
  typedef enum logic [1:0] {
    CDSG_SRC_PLL = 2'h0,
    CDSG_SRC_MAIN = 2'h1,
    CDSG_SRC_SUB = 2'h2
  } cdsg_src_type;

  typedef enum logic [2:0] {
    CDSG_MODE_RUN = 3'h0,
    CDSG_MODE_SLEEP = 3'h1,
    CDSG_MODE_PSEUDO = 3'h2,
    CDSG_MODE_CLOCK = 3'h3,
    CDSG_MODE_STOP = 3'h4,
    CDSG_MODE_INTERMIT = 3'h5
  } cdsg_mode_type;

endpackage

/* File: verilog/cdsg_prescaler.sv */
// Communications prescaler, divide machine clock by 2..8
`timescale 1ns/1ps
`default_nettype none
module cdsg_prescaler
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mclk_en,
  input wire logic [3:0] ratio,
  output logic presc_tick
);

  logic [3:0] cnt_q;
  logic [3:0] ratio_q;

  // ****************************************************************
  // Divider
  // ****************************************************************
  // Ratio is latched only at wrap so no short period appears
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q <= 4'h0;
      ratio_q <= {1'b0, cdsg_pkg::PRESC_RST};
      presc_tick <= 1'b0;
    end
    else if (mclk_en)
    begin
      if (cnt_q >= ratio_q - 4'h1)
      begin
        cnt_q <= 4'h0;
        ratio_q <= ratio;
        presc_tick <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q + 4'h1;
        presc_tick <= 1'b0;
      end
    end
    else
    begin
      presc_tick <= 1'b0;
    end
  end

  a_presc_period: assert property (@(posedge hclk) disable iff (!hresetn)
    presc_tick |-> !$past(presc_tick))
    else $error("Prescaler ticks back to back");

endmodule
`default_nettype wire

/* File: verilog/cdsg_monitor.sv */
// Clock monitor, machine clock divided by 2^(sel+1)
`timescale 1ns/1ps
`default_nettype none
module cdsg_monitor
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mclk_en,
  input wire logic [2:0] sel,
  output logic mon_out
);

  logic [7:0] cnt_q;
  logic [2:0] sel_q;
  logic [7:0] half_m1;

  // Half period is 2^sel machine cycles
  assign half_m1 = 8'((9'h001 << sel_q) - 9'h001);

  // ****************************************************************
  // Divider
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q <= 8'h00;
      sel_q <= cdsg_pkg::MONSEL_RST;
      mon_out <= 1'b0;
    end
    else if (mclk_en)
    begin
      if (cnt_q >= half_m1)
      begin
        cnt_q <= 8'h00;
        mon_out <= ~mon_out;
        // Select changes only at end of a full period
        if (mon_out)
        begin
          sel_q <= sel;
        end
      end
      else
      begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  a_mon_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !mclk_en |=> $stable(mon_out))
    else $error("Monitor pin moved while machine clock stopped");

endmodule
`default_nettype wire

/* File: verilog/cdsg_top.sv */
// Clock divider and standby gating top with AHB-Lite registers
//
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cdsg_top
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic main_osc_en,
  input wire logic pll_en,
  input wire logic sub_en,
  input wire logic hw_standby_n,
  output logic main_osc_run,
  output logic sub_osc_run,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic timebase_clk_en,
  output logic clock_timer_en,
  output logic machine_clk_en,
  output logic baud_tick,
  output logic sync_serial_tick,
  output logic clock_monitor_pin
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
    end
    else
    begin
      sync1_q <= {hw_standby_n, sub_en, pll_en, main_osc_en};
      sync2_q <= sync1_q;
    end
  end
  logic main_tick;
  logic pll_tick;
  logic sub_tick;
  logic hwstby_n;
  assign main_tick = sync2_q[0];
  assign pll_tick = sync2_q[1];
  assign sub_tick = sync2_q[2];
  assign hwstby_n = sync2_q[3];

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  logic wr_pend_q;
  logic [7:0] addr_q;
  logic [2:0] presc_q;
  logic [2:0] monsel_q;
  logic [1:0] src_q;
  logic [2:0] mode_q;
  logic [15:0] int_on_q;
  logic [15:0] int_off_q;
  logic access;
  assign access = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= access && hwrite;
      if (access)
      begin
        addr_q <= haddr;
      end
    end
  end

  // Ratio field below 2 is forced to 2 so the divide range stays legal
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      presc_q <= cdsg_pkg::PRESC_RST;
      monsel_q <= cdsg_pkg::MONSEL_RST;
      src_q <= cdsg_pkg::SRC_RST;
      mode_q <= cdsg_pkg::MODE_RST;
      int_on_q <= cdsg_pkg::INT_ON_RST;
      int_off_q <= cdsg_pkg::INT_OFF_RST;
    end
    else if (wr_pend_q)
    begin
      if (addr_q == cdsg_pkg::OFS_PRESCALE)
      begin
        presc_q <= (hwdata[2:0] < cdsg_pkg::PRESC_MIN) ? cdsg_pkg::PRESC_MIN : hwdata[2:0];
      end
      else if (addr_q == cdsg_pkg::OFS_MONITOR)
      begin
        monsel_q <= hwdata[2:0];
      end
      else if (addr_q == cdsg_pkg::OFS_MODE)
      begin
        src_q <= (hwdata[1:0] == 2'h3) ? src_q : hwdata[1:0];
        mode_q <= hwdata[6:4];
      end
      else if (addr_q == cdsg_pkg::OFS_INTERMIT)
      begin
        int_on_q <= (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
        int_off_q <= hwdata[31:16];
      end
    end
  end

  // Ratio 8 is stored as a separate bit: written bit 3 set means 8, whatever the 3-bit field holds
  logic [3:0] ratio;
  assign ratio = (presc_q == cdsg_pkg::PRESC_FIELD_MAX) ? 4'h7 : {1'b0, presc_q};
  logic ratio_eight_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ratio_eight_q <= 1'b0;
    end
    else if (wr_pend_q && addr_q == cdsg_pkg::OFS_PRESCALE)
    begin
      ratio_eight_q <= hwdata[3];
    end
  end
  logic [3:0] ratio_eff;
  assign ratio_eff = ratio_eight_q ? cdsg_pkg::PRESC_MAX : ratio;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  logic stop_all;
  logic is_pll;
  logic is_main;
  logic is_sub;
  logic win_on;
  assign is_pll = src_q == cdsg_pkg::CDSG_SRC_PLL;
  assign is_main = src_q == cdsg_pkg::CDSG_SRC_MAIN;
  assign is_sub = src_q == cdsg_pkg::CDSG_SRC_SUB;
  assign stop_all = !hwstby_n || (mode_q == cdsg_pkg::CDSG_MODE_STOP);

  // Main oscillator off under sub source, stop and standby
  assign main_osc_run = !stop_all && !is_sub;
  // Sub oscillator off only in sub stop or hardware standby
  assign sub_osc_run = !(!hwstby_n || (stop_all && is_sub));

  // Selected source tick, main divided by 2
  logic half_q;
  logic src_tick;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      half_q <= 1'b0;
    end
    else if (main_tick)
    begin
      half_q <= ~half_q;
    end
  end
  always_comb
  begin
    src_tick = 1'b0;
    if (is_pll)
    begin
      src_tick = pll_tick && main_osc_run;
    end
    else if (is_main)
    begin
      src_tick = main_tick && half_q && main_osc_run;
    end
    else if (is_sub)
    begin
      src_tick = sub_tick;
    end
  end

  // ****************************************************************
  // Intermittent window
  // ****************************************************************
  logic [15:0] win_cnt_q;
  logic win_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      win_cnt_q <= 16'h0000;
      win_q <= 1'b1;
    end
    else if (mode_q != cdsg_pkg::CDSG_MODE_INTERMIT)
    begin
      win_cnt_q <= 16'h0000;
      win_q <= 1'b1;
    end
    else if (win_cnt_q >= (win_q ? int_on_q : int_off_q) - 16'h0001)
    begin
      win_cnt_q <= 16'h0000;
      win_q <= (int_off_q == 16'h0000) ? 1'b1 : ~win_q;
    end
    else
    begin
      win_cnt_q <= win_cnt_q + 16'h0001;
    end
  end
  assign win_on = win_q;

  // ****************************************************************
  // Clock enables
  // ****************************************************************
  always_comb
  begin
    cpu_clk_en = 1'b0;
    periph_clk_en = 1'b0;
    timebase_clk_en = 1'b0;
    clock_timer_en = sub_tick && sub_osc_run;
    if (!stop_all)
    begin
      case (mode_q)
        cdsg_pkg::CDSG_MODE_RUN:
        begin
          cpu_clk_en = src_tick;
          periph_clk_en = src_tick;
          timebase_clk_en = src_tick;
        end
        cdsg_pkg::CDSG_MODE_SLEEP:
        begin
          periph_clk_en = src_tick;
          timebase_clk_en = src_tick;
        end
        cdsg_pkg::CDSG_MODE_PSEUDO:
        begin
          timebase_clk_en = is_pll && src_tick;
        end
        cdsg_pkg::CDSG_MODE_CLOCK:
        begin
          clock_timer_en = is_sub && sub_tick;
        end
        cdsg_pkg::CDSG_MODE_INTERMIT:
        begin
          cpu_clk_en = win_on && main_tick && half_q && main_osc_run;
          periph_clk_en = cpu_clk_en;
          timebase_clk_en = cpu_clk_en;
        end
        default:
        begin
          cpu_clk_en = 1'b0;
        end
      endcase
    end
  end
  assign machine_clk_en = periph_clk_en;

  // ****************************************************************
  // Prescaler and monitor
  // ****************************************************************
  logic presc_tick;
  cdsg_prescaler u_presc
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .mclk_en(machine_clk_en),
    .ratio(ratio_eff),
    .presc_tick(presc_tick)
  );
  // Both serial blocks share one tick
  assign baud_tick = presc_tick;
  assign sync_serial_tick = presc_tick;

  cdsg_monitor u_mon
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .mclk_en(machine_clk_en),
    .sel(monsel_q),
    .mon_out(clock_monitor_pin)
  );

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
    end
    else if (access && !hwrite)
    begin
      if (haddr == cdsg_pkg::OFS_PRESCALE)
      begin
        hrdata <= {28'h0000000, ratio_eight_q, presc_q};
      end
      else if (haddr == cdsg_pkg::OFS_MONITOR)
      begin
        hrdata <= {29'h00000000, monsel_q};
      end
      else if (haddr == cdsg_pkg::OFS_MODE)
      begin
        hrdata <= {25'h0000000, mode_q, 2'h0, src_q};
      end
      else if (haddr == cdsg_pkg::OFS_STATUS)
      begin
        hrdata <= {26'h0000000, cpu_clk_en, periph_clk_en, sub_osc_run, main_osc_run,
                   win_on, hwstby_n};
      end
      else if (haddr == cdsg_pkg::OFS_INTERMIT)
      begin
        hrdata <= {int_off_q, int_on_q};
      end
      else
      begin
        hrdata <= 32'h00000000;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_sleep_cpu_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_q == cdsg_pkg::CDSG_MODE_SLEEP) |-> !cpu_clk_en)
    else $error("CPU clocked in sleep");
  a_stop_halts: assert property (@(posedge hclk) disable iff (!hresetn)
    stop_all |-> !cpu_clk_en && !periph_clk_en && !main_osc_run)
    else $error("Clocks running in stop");
  a_standby_subs: assert property (@(posedge hclk) disable iff (!hresetn)
    !hwstby_n |-> !sub_osc_run)
    else $error("Sub oscillator running in standby");
  a_sub_main_off: assert property (@(posedge hclk) disable iff (!hresetn)
    is_sub |-> !main_osc_run)
    else $error("Main oscillator on under sub source");
  a_pseudo_only: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_q == cdsg_pkg::CDSG_MODE_PSEUDO) |-> !periph_clk_en && !cpu_clk_en)
    else $error("Peripherals clocked in pseudo-clock mode");
  a_shared_tick: assert property (@(posedge hclk) disable iff (!hresetn)
    baud_tick |-> sync_serial_tick && $past(machine_clk_en))
    else $error("Serial tick without a machine tick before it");
  a_intermit_gap: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_q == cdsg_pkg::CDSG_MODE_INTERMIT && !win_on) |-> !cpu_clk_en)
    else $error("CPU clocked between intermittent windows");
  // A source switch may legally put two ticks back to back
  a_main_half: assert property (@(posedge hclk) disable iff (!hresetn)
    (is_main && $past(is_main) && cpu_clk_en) |-> !$past(cpu_clk_en))
    else $error("Main source not divided by two");

endmodule
`default_nettype wire

/* File: tb/cdsg_far_model.sv */
// Far-side model: oscillator sources and the clock consumers of the block
`timescale 1ns/1ps
`default_nettype none
module cdsg_far_model
(
  input wire logic hclk,
  input wire logic clr,
  input wire logic main_osc_run,
  input wire logic sub_osc_run,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic timebase_clk_en,
  input wire logic clock_timer_en,
  input wire logic baud_tick,
  input wire logic sync_serial_tick,
  input wire logic machine_clk_en,
  input wire logic clock_monitor_pin,
  output logic main_osc_en,
  output logic pll_en,
  output logic sub_en,
  output logic [4:0] seen,
  output logic [15:0] n_cpu,
  output logic [15:0] baud_per,
  output logic [15:0] baud_min,
  output logic [15:0] mon_half,
  output logic [15:0] mon_min,
  output logic [15:0] n_split
);
  logic [1:0] pll_q = 2'h0;
  logic [2:0] sub_q = 3'h0;
  logic [15:0] bcnt_q = 16'h0;
  logic [15:0] mcnt_q = 16'h0;
  logic mon_q = 1'b0;
  // ****
  // Sources: each oscillator falls silent once its run request drops
  // ****
  always @(posedge hclk)
  begin
    pll_q <= (pll_q == 2'h2) ? 2'h0 : pll_q + 2'h1;
    sub_q <= (sub_q == 3'h4) ? 3'h0 : sub_q + 3'h1;
    main_osc_en <= main_osc_run;
    pll_en <= main_osc_run && (pll_q == 2'h0);
    sub_en <= sub_osc_run && (sub_q == 3'h0);
  end
  // ****
  // Consumers: activity, tick spacing and monitor half periods
  // ****
  always @(posedge hclk)
  begin
    mon_q <= clock_monitor_pin;
    bcnt_q <= baud_tick ? 16'h1 : bcnt_q + 16'h1;
    mcnt_q <= (clock_monitor_pin !== mon_q) ? 16'h1 : mcnt_q + 16'h1;
    if (clr)
    begin
      seen <= 5'h0;
      n_cpu <= 16'h0;
      n_split <= 16'h0;
      baud_min <= 16'hFFFF;
      mon_min <= 16'hFFFF;
    end
    else
    begin
      seen <= seen | {baud_tick, clock_timer_en, timebase_clk_en, periph_clk_en, cpu_clk_en};
      n_cpu <= n_cpu + {15'h0, cpu_clk_en};
      n_split <= n_split + {15'h0, (baud_tick !== sync_serial_tick) ||
        (machine_clk_en !== periph_clk_en)};
      if (baud_tick)
      begin
        baud_per <= bcnt_q;
        baud_min <= (bcnt_q < baud_min) ? bcnt_q : baud_min;
      end
      if (clock_monitor_pin !== mon_q)
      begin
        mon_half <= mcnt_q;
        mon_min <= (mcnt_q < mon_min) ? mcnt_q : mon_min;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/clock_divider_and_standby_gating_tb.sv */
// Self-checking bench of the clock divider and standby gating block
`timescale 1ns/1ps
`default_nettype none
module clock_divider_and_standby_gating_tb;
  typedef struct packed {logic [1:0] src; logic [3:0] presc; logic [2:0] sel;
    logic [15:0] baud; logic [15:0] half;} cdsg_div_row_type;
  typedef struct packed {logic [7:0] mode; logic [6:0] care; logic [6:0] exp;} cdsg_mode_row_type;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hw_standby_n = 1'b1;
  logic clr = 1'b0;
  logic [31:0] r;
  int n_errors = 0;
  int samples_checked = 0;
  wire [31:0] hrdata;
  wire hreadyout, main_osc_en, pll_en, sub_en, main_osc_run, sub_osc_run, cpu_clk_en;
  wire periph_clk_en, timebase_clk_en, clock_timer_en, baud_tick, sync_serial_tick, mon_pin;
  wire machine_clk_en, hresp;
  wire [4:0] seen;
  wire [15:0] n_cpu, baud_per, baud_min, mon_half, mon_min, n_split;
  // Machine period is 2 cycles on main, 3 on PLL, 5 on sub
  cdsg_div_row_type div_rows [8] = '{
    '{2'h1, 4'h2, 3'h0, 16'h0004, 16'h0002}, '{2'h1, 4'h3, 3'h1, 16'h0006, 16'h0004},
    '{2'h0, 4'h4, 3'h2, 16'h000C, 16'h000C}, '{2'h0, 4'h5, 3'h3, 16'h000F, 16'h0018},
    '{2'h2, 4'h6, 3'h4, 16'h001E, 16'h0050}, '{2'h2, 4'h7, 3'h5, 16'h0023, 16'h00A0},
    '{2'h1, 4'h8, 3'h6, 16'h0010, 16'h0080}, '{2'h1, 4'h2, 3'h7, 16'h0004, 16'h0100}};
  // Bits: baud, sub run, main run, clock timer, timebase, periph, cpu
  cdsg_mode_row_type mode_rows [11] = '{
    '{8'h00, 7'h53, 7'h53}, '{8'h10, 7'h53, 7'h52}, '{8'h20, 7'h17, 7'h14},
    '{8'h40, 7'h53, 7'h00}, '{8'h01, 7'h53, 7'h53}, '{8'h11, 7'h53, 7'h52},
    '{8'h41, 7'h53, 7'h00}, '{8'h02, 7'h73, 7'h63}, '{8'h12, 7'h73, 7'h62},
    '{8'h32, 7'h3B, 7'h28}, '{8'h42, 7'h73, 7'h00}};
  cdsg_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .main_osc_en(main_osc_en), .pll_en(pll_en),
    .sub_en(sub_en), .hw_standby_n(hw_standby_n), .main_osc_run(main_osc_run),
    .sub_osc_run(sub_osc_run), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .timebase_clk_en(timebase_clk_en), .clock_timer_en(clock_timer_en),
    .machine_clk_en(machine_clk_en),
    .baud_tick(baud_tick), .sync_serial_tick(sync_serial_tick), .clock_monitor_pin(mon_pin));
  cdsg_far_model far_u (.hclk(hclk), .clr(clr), .main_osc_run(main_osc_run),
    .sub_osc_run(sub_osc_run), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .timebase_clk_en(timebase_clk_en), .clock_timer_en(clock_timer_en),
    .baud_tick(baud_tick), .sync_serial_tick(sync_serial_tick), .clock_monitor_pin(mon_pin),
    .machine_clk_en(machine_clk_en),
    .main_osc_en(main_osc_en), .pll_en(pll_en), .sub_en(sub_en), .seen(seen), .n_cpu(n_cpu),
    .baud_per(baud_per), .baud_min(baud_min), .mon_half(mon_half), .mon_min(mon_min),
    .n_split(n_split));
  always #10 hclk = ~hclk;
  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    samples_checked++;
    if (seen_v !== exp_v)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic window(input int n);
    @(posedge hclk);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    repeat (n) @(posedge hclk);
  endtask
  task automatic reset_check();
    bus(1'b0, cdsg_pkg::OFS_PRESCALE, 32'h0);
    chk(r, {29'h0, cdsg_pkg::PRESC_RST});
    chk({31'h0, hresp}, 32'h0);
    bus(1'b0, cdsg_pkg::OFS_MONITOR, 32'h0);
    chk(r, {29'h0, cdsg_pkg::MONSEL_RST});
    bus(1'b0, cdsg_pkg::OFS_MODE, 32'h0);
    chk(r, {25'h0, cdsg_pkg::MODE_RST, 2'h0, cdsg_pkg::SRC_RST});
    bus(1'b0, cdsg_pkg::OFS_INTERMIT, 32'h0);
    chk(r, {cdsg_pkg::INT_OFF_RST, cdsg_pkg::INT_ON_RST});
    bus(1'b0, 8'h14, 32'h0);
    chk(r, 32'h0);
  endtask
  task automatic stop_test();
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    reset_check();
    foreach (div_rows[i])
    begin
      bus(1'b1, cdsg_pkg::OFS_MODE, {30'h0, div_rows[i].src});
      bus(1'b1, cdsg_pkg::OFS_PRESCALE, {28'h0, div_rows[i].presc});
      bus(1'b1, cdsg_pkg::OFS_MONITOR, {29'h0, div_rows[i].sel});
      repeat (600) @(posedge hclk);
      window(700);
      chk({16'h0, baud_per}, {16'h0, div_rows[i].baud});
      chk({16'h0, baud_min}, {16'h0, div_rows[i].baud});
      chk({16'h0, mon_half}, {16'h0, div_rows[i].half});
      chk({16'h0, mon_min}, {16'h0, div_rows[i].half});
      chk({16'h0, n_split}, 32'h0);
    end
    foreach (mode_rows[i])
    begin
      bus(1'b1, cdsg_pkg::OFS_MODE, {24'h0, mode_rows[i].mode});
      repeat (100) @(posedge hclk);
      window(200);
      r = {25'h0, seen[4], sub_osc_run, main_osc_run, seen[3:0]};
      chk(r & {25'h0, mode_rows[i].care}, {25'h0, mode_rows[i].exp});
    end
    // Ratio and select changed mid-stream must never shorten a pulse
    bus(1'b1, cdsg_pkg::OFS_MODE, 32'h1);
    bus(1'b1, cdsg_pkg::OFS_PRESCALE, 32'h7);
    bus(1'b1, cdsg_pkg::OFS_MONITOR, 32'h3);
    repeat (300) @(posedge hclk);
    window(20);
    bus(1'b1, cdsg_pkg::OFS_PRESCALE, 32'h3);
    bus(1'b1, cdsg_pkg::OFS_MONITOR, 32'h1);
    repeat (300) @(posedge hclk);
    chk({31'h0, baud_min >= 16'h0006}, 32'h1);
    chk({31'h0, mon_min >= 16'h0004}, 32'h1);
    chk({16'h0, baud_per}, 32'h6);
    bus(1'b1, cdsg_pkg::OFS_MODE, 32'h51);
    repeat (100) @(posedge hclk);
    window(640);
    chk({31'h0, n_cpu > 16'h0 && n_cpu < 16'h006E}, 32'h1);
    bus(1'b1, cdsg_pkg::OFS_MODE, 32'h1);
    hw_standby_n <= 1'b0;
    repeat (50) @(posedge hclk);
    bus(1'b0, cdsg_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, r[0]}, 32'h0);
    window(200);
    chk({29'h0, seen[0], main_osc_run, sub_osc_run}, 32'h0);
    hw_standby_n <= 1'b1;
    bus(1'b1, cdsg_pkg::OFS_PRESCALE, 32'h5);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    reset_check();
    stop_test();
  end
  initial
  begin
    #1200000;
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
